// File: core/cfg_bank_pkg.sv
// Shared constants for the logical device configuration bank
package cfg_bank_pkg;
  localparam int UNITS = 7;
  localparam int SLOTS = 12;
  // Unit numbers
  localparam logic [2:0] UNIT_FLOPPY = 3'h0;
  localparam logic [2:0] UNIT_UART1 = 3'h1;
  localparam logic [2:0] UNIT_UART2 = 3'h2;
  localparam logic [2:0] UNIT_LPT = 3'h3;
  localparam logic [2:0] UNIT_CLOCK = 3'h4;
  localparam logic [2:0] UNIT_KBD = 3'h5;
  localparam logic [2:0] UNIT_MOUSE = 3'h6;
  // Storage slots inside one unit
  localparam logic [3:0] SLOT_ACT = 4'h0;
  localparam logic [3:0] SLOT_RANGE = 4'h1;
  localparam logic [3:0] SLOT_BASE_HI = 4'h2;
  localparam logic [3:0] SLOT_BASE_LO = 4'h3;
  localparam logic [3:0] SLOT_BASE2_HI = 4'h4;
  localparam logic [3:0] SLOT_BASE2_LO = 4'h5;
  localparam logic [3:0] SLOT_IRQ_LEVEL = 4'h6;
  localparam logic [3:0] SLOT_IRQ_TYPE = 4'h7;
  localparam logic [3:0] SLOT_DMA = 4'h8;
  localparam logic [3:0] SLOT_CFG_A = 4'h9;
  localparam logic [3:0] SLOT_CFG_B = 4'ha;
  localparam logic [3:0] SLOT_CFG_C = 4'hb;
  // Register indices
  localparam logic [7:0] IDX_UNIT_NUM = 8'h07;
  localparam logic [7:0] IDX_UNIT_ENABLE = 8'h23;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_RANGE = 8'h31;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_LEVEL = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_CFG_A = 8'hf0;
  localparam logic [7:0] IDX_CFG_B = 8'hf1;
  localparam logic [7:0] IDX_CFG_C = 8'hf2;
  // Access classes
  localparam logic [1:0] ACC_BOTH = 2'h0;
  localparam logic [1:0] ACC_BUS = 2'h1;
  localparam logic [1:0] ACC_BOARD = 2'h2;
  // Field positions
  localparam int TYPE_WE_BIT = 0;
  localparam int STATUS_SPLIT = 4;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_IRQ_TYPE = 8'h02;
  localparam logic [7:0] RST_FLOPPY_BASE_HI = 8'h03;
  localparam logic [7:0] RST_FLOPPY_BASE_LO = 8'hf0;
  localparam logic [7:0] RST_FLOPPY_IRQ = 8'h06;
  localparam logic [7:0] RST_FLOPPY_DMA = 8'h02;
  localparam logic [7:0] RST_UART1_BASE_HI = 8'h03;
  localparam logic [7:0] RST_UART1_BASE_LO = 8'hf8;
  localparam logic [7:0] RST_UART1_IRQ = 8'h04;
  localparam logic [7:0] RST_UART2_BASE_HI = 8'h02;
  localparam logic [7:0] RST_UART2_BASE_LO = 8'hf8;
  localparam logic [7:0] RST_UART2_IRQ = 8'h03;
  localparam logic [7:0] RST_LPT_BASE_HI = 8'h03;
  localparam logic [7:0] RST_LPT_BASE_LO = 8'h78;
  localparam logic [7:0] RST_LPT_IRQ = 8'h07;
  localparam logic [7:0] RST_LPT_DMA = 8'h03;
  localparam logic [7:0] RST_LPT_CFG = 8'h03;
  localparam logic [7:0] RST_CLOCK_BASE_LO = 8'h70;
  localparam logic [7:0] RST_CLOCK_IRQ = 8'h08;
  localparam logic [7:0] RST_KBD_DATA_LO = 8'h60;
  localparam logic [7:0] RST_KBD_CMD_LO = 8'h64;
  localparam logic [7:0] RST_KBD_IRQ = 8'h01;
  localparam logic [7:0] RST_MOUSE_IRQ = 8'h0c;
endpackage

// File: core/logical_device_config_bank.sv
// Per-unit configuration register bank behind the index/data configuration port
//
// Contract
// - Floppy base resets to 03h/F0h, RW both
// - Floppy irq level resets 06h, RW both
// - Floppy DMA select at 74h resets 02h
// - Serial one base resets 03h/F8h
// - Serial one irq level resets 04h
// - Serial two base resets 02h/F8h
// - Serial two irq level resets 03h
// - Serial two F0h/F1h zero, board mode only
// - Parallel base resets 03h/78h
// - Parallel irq 07h, DMA 03h
// - Parallel F0h resets 03h, board only
// - Clock base 00h/70h, irq 08h
// - Power F0h-F2h zero, board only, mixed status
// - Keyboard data/command bases 60h/64h at 60h-63h
// - Keyboard irq 01h, type reachable both modes
// - Mouse activate, irq 0Ch, type, config
// - Activate at 30h RW both, zero reset
// - Range check at 31h zero, bus mode only
// - Floppy F0h zero, board mode only
// - Clock and keyboard activate from straps
// - Bus mode maps numbers over enabled units
// - Keyboard/mouse type writable only with enable
`timescale 1ns/1ns
module logical_device_config_bank (
  input wire logic clock,
  input wire logic rstn,
  input wire logic bus_autoconfig_mode,
  input wire logic board_config_mode,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_write,
  input wire logic cfg_read,
  output logic [7:0] cfg_rdata,
  input wire logic strap_pin_three,
  input wire logic strap_pin_four,
  input wire logic [3:0] power_event,
  output logic [6:0] unit_active,
  output logic strap_done
);
  logic [7:0] regs [cfg_bank_pkg::UNITS][cfg_bank_pkg::SLOTS];
  logic [7:0] logical_unit_number;
  logic [6:0] unit_enable;
  logic [2:0] sync_three;
  logic [2:0] sync_four;
  logic [2:0] sync_fill;
  logic [3:0] mapped;
  logic [4:0] decoded;
  logic [2:0] cur_unit;
  logic [3:0] cur_slot;
  logic hit;
  logic allowed;
  logic writable;
  logic do_write;
  logic status_write;
  logic strap_load;
  logic [7:0] status_now;
  logic [7:0] next_status;
  logic [3:0] status_clear;

  // Reset value of each slot of each unit
  function automatic logic [7:0] reset_value(input logic [2:0] u, input logic [3:0] s);
    logic [7:0] v;
    v = cfg_bank_pkg::RST_ZERO;
    if (s == cfg_bank_pkg::SLOT_IRQ_TYPE) begin
      v = cfg_bank_pkg::RST_IRQ_TYPE;
    end
    case (u)
      cfg_bank_pkg::UNIT_FLOPPY: begin
        if (s == cfg_bank_pkg::SLOT_BASE_HI) v = cfg_bank_pkg::RST_FLOPPY_BASE_HI;
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_FLOPPY_BASE_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_FLOPPY_IRQ;
        if (s == cfg_bank_pkg::SLOT_DMA) v = cfg_bank_pkg::RST_FLOPPY_DMA;
      end
      cfg_bank_pkg::UNIT_UART1: begin
        if (s == cfg_bank_pkg::SLOT_BASE_HI) v = cfg_bank_pkg::RST_UART1_BASE_HI;
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_UART1_BASE_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_UART1_IRQ;
      end
      cfg_bank_pkg::UNIT_UART2: begin
        if (s == cfg_bank_pkg::SLOT_BASE_HI) v = cfg_bank_pkg::RST_UART2_BASE_HI;
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_UART2_BASE_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_UART2_IRQ;
      end
      cfg_bank_pkg::UNIT_LPT: begin
        if (s == cfg_bank_pkg::SLOT_BASE_HI) v = cfg_bank_pkg::RST_LPT_BASE_HI;
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_LPT_BASE_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_LPT_IRQ;
        if (s == cfg_bank_pkg::SLOT_DMA) v = cfg_bank_pkg::RST_LPT_DMA;
        if (s == cfg_bank_pkg::SLOT_CFG_A) v = cfg_bank_pkg::RST_LPT_CFG;
      end
      cfg_bank_pkg::UNIT_CLOCK: begin
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_CLOCK_BASE_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_CLOCK_IRQ;
      end
      cfg_bank_pkg::UNIT_KBD: begin
        if (s == cfg_bank_pkg::SLOT_BASE_LO) v = cfg_bank_pkg::RST_KBD_DATA_LO;
        if (s == cfg_bank_pkg::SLOT_BASE2_LO) v = cfg_bank_pkg::RST_KBD_CMD_LO;
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_KBD_IRQ;
      end
      cfg_bank_pkg::UNIT_MOUSE: begin
        if (s == cfg_bank_pkg::SLOT_IRQ_LEVEL) v = cfg_bank_pkg::RST_MOUSE_IRQ;
      end
      default: begin
        v = cfg_bank_pkg::RST_ZERO;
      end
    endcase
    return v;
  endfunction

  // Index to slot; top bit flags a known index
  function automatic logic [4:0] slot_of(input logic [7:0] idx);
    logic [4:0] r;
    r = 5'h00;
    case (idx)
      cfg_bank_pkg::IDX_ACT: r = {1'b1, cfg_bank_pkg::SLOT_ACT};
      cfg_bank_pkg::IDX_RANGE: r = {1'b1, cfg_bank_pkg::SLOT_RANGE};
      cfg_bank_pkg::IDX_BASE_HI: r = {1'b1, cfg_bank_pkg::SLOT_BASE_HI};
      cfg_bank_pkg::IDX_BASE_LO: r = {1'b1, cfg_bank_pkg::SLOT_BASE_LO};
      cfg_bank_pkg::IDX_BASE2_HI: r = {1'b1, cfg_bank_pkg::SLOT_BASE2_HI};
      cfg_bank_pkg::IDX_BASE2_LO: r = {1'b1, cfg_bank_pkg::SLOT_BASE2_LO};
      cfg_bank_pkg::IDX_IRQ_LEVEL: r = {1'b1, cfg_bank_pkg::SLOT_IRQ_LEVEL};
      cfg_bank_pkg::IDX_IRQ_TYPE: r = {1'b1, cfg_bank_pkg::SLOT_IRQ_TYPE};
      cfg_bank_pkg::IDX_DMA: r = {1'b1, cfg_bank_pkg::SLOT_DMA};
      cfg_bank_pkg::IDX_CFG_A: r = {1'b1, cfg_bank_pkg::SLOT_CFG_A};
      cfg_bank_pkg::IDX_CFG_B: r = {1'b1, cfg_bank_pkg::SLOT_CFG_B};
      cfg_bank_pkg::IDX_CFG_C: r = {1'b1, cfg_bank_pkg::SLOT_CFG_C};
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // Which slots a unit really has
  function automatic logic present(input logic [2:0] u, input logic [3:0] s);
    logic p;
    p = 1'b0;
    case (s)
      cfg_bank_pkg::SLOT_ACT, cfg_bank_pkg::SLOT_IRQ_LEVEL, cfg_bank_pkg::SLOT_IRQ_TYPE,
      cfg_bank_pkg::SLOT_CFG_A: p = 1'b1;
      cfg_bank_pkg::SLOT_RANGE, cfg_bank_pkg::SLOT_BASE_HI, cfg_bank_pkg::SLOT_BASE_LO:
        p = (u != cfg_bank_pkg::UNIT_MOUSE);
      cfg_bank_pkg::SLOT_BASE2_HI, cfg_bank_pkg::SLOT_BASE2_LO:
        p = (u == cfg_bank_pkg::UNIT_KBD);
      cfg_bank_pkg::SLOT_DMA: p = (u == cfg_bank_pkg::UNIT_FLOPPY) || (u == cfg_bank_pkg::UNIT_LPT);
      cfg_bank_pkg::SLOT_CFG_B: p = (u == cfg_bank_pkg::UNIT_UART2) || (u == cfg_bank_pkg::UNIT_CLOCK);
      cfg_bank_pkg::SLOT_CFG_C: p = (u == cfg_bank_pkg::UNIT_CLOCK);
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  // Configuration mode(s) in which a slot may be reached
  function automatic logic [1:0] access_of(input logic [2:0] u, input logic [3:0] s);
    logic [1:0] a;
    a = cfg_bank_pkg::ACC_BOTH;
    case (s)
      cfg_bank_pkg::SLOT_RANGE: a = cfg_bank_pkg::ACC_BUS;
      cfg_bank_pkg::SLOT_IRQ_TYPE:
        a = (u <= cfg_bank_pkg::UNIT_CLOCK) ? cfg_bank_pkg::ACC_BUS : cfg_bank_pkg::ACC_BOTH;
      cfg_bank_pkg::SLOT_CFG_A, cfg_bank_pkg::SLOT_CFG_B, cfg_bank_pkg::SLOT_CFG_C:
        a = cfg_bank_pkg::ACC_BOARD;
      default: a = cfg_bank_pkg::ACC_BOTH;
    endcase
    return a;
  endfunction

  // Unit behind a logical number; top bit flags a valid unit
  function automatic logic [3:0] map_unit(input logic [7:0] lun, input logic [6:0] en,
                                          input logic bus);
    logic [3:0] r;
    logic [7:0] n;
    r = 4'h0;
    n = 8'h00;
    if (!bus) begin
      if (lun < 8'(cfg_bank_pkg::UNITS)) begin
        r = {1'b1, lun[2:0]};
      end
    end else begin
      for (int i = 0; i < cfg_bank_pkg::UNITS; i++) begin
        if (en[i]) begin
          if (n == lun && !r[3]) begin
            r = {1'b1, 3'(i)};
          end
          n = n + 8'h01;
        end
      end
    end
    return r;
  endfunction

  // Decode of the current access
  always_comb begin
    mapped = map_unit(logical_unit_number, unit_enable, bus_autoconfig_mode && !board_config_mode);
    decoded = slot_of(cfg_index);
    cur_unit = mapped[2:0];
    cur_slot = decoded[3:0];
    hit = mapped[3] && decoded[4] && present(cur_unit, cur_slot);
    case (access_of(cur_unit, cur_slot))
      cfg_bank_pkg::ACC_BUS: allowed = bus_autoconfig_mode;
      cfg_bank_pkg::ACC_BOARD: allowed = board_config_mode;
      default: allowed = bus_autoconfig_mode || board_config_mode;
    endcase
    writable = 1'b1;
    if (cur_slot == cfg_bank_pkg::SLOT_IRQ_TYPE) begin
      writable = 1'b0;
      if (cur_unit == cfg_bank_pkg::UNIT_KBD || cur_unit == cfg_bank_pkg::UNIT_MOUSE) begin
        writable = regs[cur_unit][cfg_bank_pkg::SLOT_CFG_A][cfg_bank_pkg::TYPE_WE_BIT];
      end
    end
    status_write = cfg_write && hit && allowed && cur_unit == cfg_bank_pkg::UNIT_CLOCK &&
                   cur_slot == cfg_bank_pkg::SLOT_CFG_C;
    do_write = cfg_write && hit && allowed && writable && !status_write;
  end

  // Power status: upper half sticky events cleared by writing ones, lower half plain
  always_comb begin
    status_now = regs[cfg_bank_pkg::UNIT_CLOCK][cfg_bank_pkg::SLOT_CFG_C];
    status_clear = status_write ? cfg_wdata[7:cfg_bank_pkg::STATUS_SPLIT] : 4'h0;
    next_status[7:cfg_bank_pkg::STATUS_SPLIT] =
      (status_now[7:cfg_bank_pkg::STATUS_SPLIT] & ~status_clear) | power_event;
    next_status[cfg_bank_pkg::STATUS_SPLIT-1:0] = status_write ?
      cfg_wdata[cfg_bank_pkg::STATUS_SPLIT-1:0] : status_now[cfg_bank_pkg::STATUS_SPLIT-1:0];
  end

  // Strap synchronisers
  // Fill marks stages that hold sampled pin levels, not their reset zeros
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_three <= 3'h0;
      sync_four <= 3'h0;
      sync_fill <= 3'h0;
    end else begin
      sync_three <= {sync_three[1:0], strap_pin_three};
      sync_four <= {sync_four[1:0], strap_pin_four};
      sync_fill <= {sync_fill[1:0], 1'b1};
    end
  end

  assign strap_load = !strap_done && sync_fill[2] && (sync_three[1] == sync_three[2]) &&
                      (sync_four[1] == sync_four[2]);

  // Straps are caught once, when the synchronised levels settle after reset release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_done <= 1'b0;
    end else if (strap_load) begin
      strap_done <= 1'b1;
    end
  end

  // Global selectors
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      logical_unit_number <= cfg_bank_pkg::RST_ZERO;
      unit_enable <= 7'h00;
    end else if (cfg_write) begin
      if (cfg_index == cfg_bank_pkg::IDX_UNIT_NUM &&
          (bus_autoconfig_mode || board_config_mode)) begin
        logical_unit_number <= cfg_wdata;
      end
      if (cfg_index == cfg_bank_pkg::IDX_UNIT_ENABLE && board_config_mode) begin
        unit_enable <= cfg_wdata[6:0];
      end
    end
  end

  // Unit register storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int u = 0; u < cfg_bank_pkg::UNITS; u++) begin
        for (int s = 0; s < cfg_bank_pkg::SLOTS; s++) begin
          regs[u][s] <= reset_value(3'(u), 4'(s));
        end
      end
    end else begin
      if (do_write) begin
        regs[cur_unit][cur_slot] <= cfg_wdata;
      end
      regs[cfg_bank_pkg::UNIT_CLOCK][cfg_bank_pkg::SLOT_CFG_C] <= next_status;
      if (strap_load) begin
        regs[cfg_bank_pkg::UNIT_CLOCK][cfg_bank_pkg::SLOT_ACT][0] <= sync_three[2];
        regs[cfg_bank_pkg::UNIT_KBD][cfg_bank_pkg::SLOT_ACT][0] <= sync_four[2];
      end
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= cfg_bank_pkg::RST_ZERO;
    end else if (cfg_read) begin
      if (cfg_index == cfg_bank_pkg::IDX_UNIT_NUM) begin
        cfg_rdata <= logical_unit_number;
      end else if (cfg_index == cfg_bank_pkg::IDX_UNIT_ENABLE && board_config_mode) begin
        cfg_rdata <= {1'b0, unit_enable};
      end else if (hit && allowed) begin
        cfg_rdata <= regs[cur_unit][cur_slot];
      end else begin
        cfg_rdata <= cfg_bank_pkg::RST_ZERO;
      end
    end
  end

  for (genvar g = 0; g < cfg_bank_pkg::UNITS; g++) begin : g_active
    assign unit_active[g] = regs[g][cfg_bank_pkg::SLOT_ACT][0];
  end

  // Checks
  logic any_write;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      any_write <= 1'b0;
    end else if (cfg_write) begin
      any_write <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence range_write_s;
    cfg_write && cfg_index == cfg_bank_pkg::IDX_RANGE && !bus_autoconfig_mode;
  endsequence

  sequence board_write_s;
    cfg_write && cfg_index == cfg_bank_pkg::IDX_CFG_A && !board_config_mode &&
    logical_unit_number == 8'h00;
  endsequence

  sequence map_read_s;
    cfg_read && bus_autoconfig_mode && !board_config_mode &&
    cfg_index == cfg_bank_pkg::IDX_BASE_HI &&
    logical_unit_number == 8'h00 && unit_enable == 7'h06;
  endsequence

  floppy_base_reset_a: assert property (!any_write |->
    regs[0][cfg_bank_pkg::SLOT_BASE_HI] == 8'h03 && regs[0][cfg_bank_pkg::SLOT_BASE_LO] == 8'hf0)
    else $error("floppy base not at default");
  uart_base_reset_a: assert property (!any_write |->
    regs[1][cfg_bank_pkg::SLOT_BASE_LO] == 8'hf8 && regs[2][cfg_bank_pkg::SLOT_BASE_HI] == 8'h02)
    else $error("serial base not at default");
  lpt_reset_a: assert property (!any_write |->
    regs[3][cfg_bank_pkg::SLOT_BASE_LO] == 8'h78 && regs[3][cfg_bank_pkg::SLOT_CFG_A] == 8'h03)
    else $error("parallel defaults wrong");
  irq_type_const_a: assert property (regs[0][cfg_bank_pkg::SLOT_IRQ_TYPE] == 8'h02 &&
    regs[4][cfg_bank_pkg::SLOT_IRQ_TYPE] == 8'h02)
    else $error("fixed interrupt type changed");
  range_guard_a: assert property (range_write_s |=>
    $stable(regs[0][cfg_bank_pkg::SLOT_RANGE]))
    else $error("range check written outside bus mode");
  board_guard_a: assert property (board_write_s |=>
    $stable(regs[0][cfg_bank_pkg::SLOT_CFG_A]))
    else $error("special config written outside board mode");
  type_lock_a: assert property (cfg_write && cfg_index == cfg_bank_pkg::IDX_IRQ_TYPE &&
    !regs[5][cfg_bank_pkg::SLOT_CFG_A][0] |=> $stable(regs[5][cfg_bank_pkg::SLOT_IRQ_TYPE]))
    else $error("locked interrupt type written");
  strap_latch_a: assert property ($rose(strap_done) |->
    regs[4][cfg_bank_pkg::SLOT_ACT][0] == $past(sync_three[2]) &&
    regs[5][cfg_bank_pkg::SLOT_ACT][0] == $past(sync_four[2]))
    else $error("strap not latched into activate");
  strap_time_a: assert property ($rose(rstn) |-> ##[0:5] strap_done)
    else $error("strap latch late");
  unit_map_a: assert property (map_read_s |=>
    cfg_rdata == $past(regs[1][cfg_bank_pkg::SLOT_BASE_HI]))
    else $error("bus mode number not mapped");
  status_sticky_a: assert property (power_event[0] |=>
    regs[4][cfg_bank_pkg::SLOT_CFG_C][4])
    else $error("power event lost");
  range_read_a: assert property (cfg_read && cfg_index == cfg_bank_pkg::IDX_RANGE &&
    !bus_autoconfig_mode |=> cfg_rdata == cfg_bank_pkg::RST_ZERO)
    else $error("range check read outside bus mode");
endmodule

// File: test/cfg_host.sv
// Host-side model that drives the configuration register port
`timescale 1ns/1ns
module cfg_host (
  input wire logic clock,
  input wire logic [7:0] cfg_rdata,
  output logic [7:0] cfg_index,
  output logic [7:0] cfg_wdata,
  output logic cfg_write,
  output logic cfg_read
);
  initial begin
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    cfg_write = 1'b0;
    cfg_read = 1'b0;
  end
  // Released lines carry the inverse so a stale value never looks valid
  task automatic drop();
    cfg_write = 1'b0;
    cfg_read = 1'b0;
    cfg_index = ~cfg_index;
    cfg_wdata = ~cfg_wdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge clock);
    #1;
    cfg_index = idx;
    cfg_wdata = data;
    cfg_write = 1'b1;
    @(posedge clock);
    #1;
    drop();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] data);
    @(posedge clock);
    #1;
    cfg_index = idx;
    cfg_read = 1'b1;
    @(posedge clock);
    #1;
    data = cfg_rdata;
    drop();
  endtask
  // Unit number goes in before any unit register is touched
  task automatic sel(input logic [2:0] unit);
    wr(8'h07, {5'h00, unit});
  endtask
endmodule

// File: test/logical_device_config_bank_bench.sv
// Self-checking bench for the logical device configuration bank
`timescale 1ns/1ns
module logical_device_config_bank_bench;
  logic clock, rstn, bus_autoconfig_mode, board_config_mode, cfg_write, cfg_read;
  logic strap_pin_three, strap_pin_four, strap_done;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata, v;
  logic [3:0] power_event;
  logic [6:0] unit_active;
  int n_mismatch = 0;
  int n_checks = 0;
  // Board-mode reset image: unit, index, value
  logic [19:0] rst_tbl [42] = '{
    20'h0_30_00, 20'h0_60_03, 20'h0_61_f0, 20'h0_70_06,
    20'h0_74_02, 20'h0_f0_00, 20'h1_30_00, 20'h1_60_03,
    20'h1_61_f8, 20'h1_70_04, 20'h1_f0_00, 20'h2_30_00,
    20'h2_60_02, 20'h2_61_f8, 20'h2_70_03, 20'h2_f0_00,
    20'h2_f1_00, 20'h3_30_00, 20'h3_60_03, 20'h3_61_78,
    20'h3_70_07, 20'h3_74_03, 20'h3_f0_03, 20'h4_30_01,
    20'h4_60_00, 20'h4_61_70, 20'h4_70_08, 20'h4_f0_00,
    20'h4_f1_00, 20'h4_f2_00, 20'h5_30_00, 20'h5_60_00,
    20'h5_61_60, 20'h5_62_00, 20'h5_63_64, 20'h5_70_01,
    20'h5_71_02, 20'h5_f0_00, 20'h6_30_00, 20'h6_70_0c,
    20'h6_71_02, 20'h6_f0_00};

  logical_device_config_bank dut (.clock(clock), .rstn(rstn),
    .bus_autoconfig_mode(bus_autoconfig_mode), .board_config_mode(board_config_mode),
    .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
    .cfg_read(cfg_read), .cfg_rdata(cfg_rdata), .strap_pin_three(strap_pin_three),
    .strap_pin_four(strap_pin_four), .power_event(power_event),
    .unit_active(unit_active), .strap_done(strap_done));
  cfg_host host (.clock(clock), .cfg_rdata(cfg_rdata), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] u, input logic [7:0] idx, input logic [7:0] exp);
    host.sel(u);
    host.rd(idx, v);
    check(v, exp);
  endtask
  task automatic mode(input logic bus, input logic board);
    @(posedge clock);
    #1;
    bus_autoconfig_mode = bus;
    board_config_mode = board;
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reset_image();
    mode(1'b0, 1'b1);
    foreach (rst_tbl[i]) rchk(rst_tbl[i][18:16], rst_tbl[i][15:8], rst_tbl[i][7:0]);
    check({1'b0, unit_active}, 8'h10);
    check({7'h00, strap_done}, 8'h01);
  endtask
  task automatic bus_access();
    mode(1'b0, 1'b1);
    host.wr(8'h23, 8'h7f);
    mode(1'b1, 1'b0);
    for (int u = 0; u < 5; u++) begin
      host.sel(3'(u));
      host.wr(8'h71, 8'h05);
      host.rd(8'h71, v);
      check(v, 8'h02);
    end
    host.wr(8'h31, 8'h55);
    rchk(3'h4, 8'h31, 8'h55);
    host.wr(8'hf0, 8'h5a);
    host.rd(8'hf0, v);
    check(v, 8'h00);
    mode(1'b0, 1'b1);
    rchk(3'h4, 8'hf0, 8'h00);
    host.rd(8'h31, v);
    check(v, 8'h00);
  endtask
  task automatic rw_both();
    mode(1'b1, 1'b0);
    host.sel(3'h0);
    host.wr(8'h61, 8'ha8);
    rchk(3'h0, 8'h61, 8'ha8);
    host.wr(8'hf0, 8'h77);
    mode(1'b0, 1'b1);
    host.wr(8'h31, 8'h33);
    rchk(3'h0, 8'hf0, 8'h00);
    host.wr(8'h74, 8'h01);
    rchk(3'h0, 8'h74, 8'h01);
    host.sel(3'h3);
    host.wr(8'h30, 8'h01);
    check({1'b0, unit_active}, 8'h18);
    host.sel(3'h5);
    host.wr(8'h71, 8'h03);
    rchk(3'h5, 8'h71, 8'h02);
    host.wr(8'hf0, 8'h01);
    host.wr(8'h71, 8'h03);
    rchk(3'h5, 8'h71, 8'h03);
    mode(1'b1, 1'b0);
    rchk(3'h0, 8'h31, 8'h00);
  endtask
  task automatic mapping();
    mode(1'b0, 1'b1);
    host.wr(8'h23, 8'h06);
    mode(1'b1, 1'b0);
    rchk(3'h0, 8'h60, 8'h03);
    rchk(3'h1, 8'h60, 8'h02);
    mode(1'b0, 1'b1);
    rchk(3'h1, 8'h60, 8'h03);
  endtask
  task automatic power_status();
    @(posedge clock);
    #1 power_event = 4'h5;
    @(posedge clock);
    #1 power_event = 4'h0;
    rchk(3'h4, 8'hf2, 8'h50);
    host.wr(8'hf2, 8'h1f);
    host.rd(8'hf2, v);
    check(v, 8'h4f);
  endtask
  // Second reset with the straps the other way round
  task automatic strap_swap();
    @(posedge clock);
    #1 rstn = 1'b0;
    strap_pin_three = 1'b0;
    strap_pin_four = 1'b1;
    repeat (2) @(posedge clock);
    check({1'b0, unit_active}, 8'h00);
    check({7'h00, strap_done}, 8'h00);
    #1 rstn = 1'b1;
    repeat (6) @(posedge clock);
    check({1'b0, unit_active}, 8'h20);
    rchk(3'h5, 8'h30, 8'h01);
    rchk(3'h0, 8'h61, 8'hf0);
  endtask

  initial begin
    rstn = 1'b0;
    bus_autoconfig_mode = 1'b0;
    board_config_mode = 1'b0;
    strap_pin_three = 1'b1;
    strap_pin_four = 1'b0;
    power_event = 4'h0;
    repeat (16) @(posedge clock);
    #1 rstn = 1'b1;
    for (int i = 0; i < 20 && strap_done !== 1'b1; i++) @(posedge clock);
    reset_image();
    bus_access();
    rw_both();
    mapping();
    power_status();
    strap_swap();
    complete_run();
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
